/* File: src/erac_top.v */
// eprom read-access control: control register, array read gating, program latches
//
// Overview of operation
// RL1 - clearing the latch bit forces the program-enable bit to zero
// RL2 - latch clear: fetches and loads return true array contents like mask rom
// RL3 - latch set: array reads return data unrelated to contents
// RL4 - latch set: vector fetches are not valid
// RL5 - software must not run bootstrap routines while latch set
// RL6 - stop entry returns eprom to read mode, clearing latch and program enable
// RL7 - an erased byte reads as all zeros
// RL8 - 31232 eprom bytes with 14 vector bytes, plus 256 eeprom bytes
// RL9 - up to 16 bytes latched for one simultaneous programming
// RL10 - option word sits in eprom cells; no reset alters it
// RL11 - stop, power-on and external reset clear the latch bit
// RL12 - software writes never clear program enable directly
`timescale 1ns/1ps
`include "erac_map.vh"

module erac_top (
  input  wire        clk_i,         // cpu clock, 40 MHz
  input  wire        rst_i,         // synchronous reset, active high
  input  wire        ext_rst_i,     // external reset request, level
  input  wire        stop_i,        // stop-mode entry pulse
  input  wire        wb_cyc_i,      // wishbone cycle
  input  wire        wb_stb_i,      // wishbone strobe
  input  wire        wb_we_i,       // wishbone write enable
  input  wire [15:0] wb_adr_i,      // wishbone byte address
  input  wire [7:0]  wb_dat_i,      // wishbone write data
  input  wire [0:0]  wb_sel_i,      // wishbone byte select
  output reg  [7:0]  wb_dat_o,      // wishbone read data
  output wire        wb_ack_o,      // wishbone acknowledge
  output wire        wb_err_o,      // wishbone error, unmapped address
  input  wire [7:0]  opt_cells_i,   // option word cell contents
  input  wire        fetch_i,       // cpu is fetching an instruction
  input  wire        vector_i,      // cpu is fetching a vector
  output wire        vector_ok_o,   // vector fetch valid
  output wire        read_mode_o,   // eprom in read mode
  output wire        prog_on_o,     // program pulse active
  output wire        clk_out_en_o,  // clock output enable bit
  output wire [3:0]  prog_cnt_o,    // index of last latched byte
  output wire [7:0]  prog_mask_o,   // or of latched data bytes
  output wire [11:0] prog_row_o     // latched row address bits
);

  reg         eprom_latch_enable_ff;
  reg         nxt_eprom_latch_enable;
  reg         eprom_program_enable_ff;
  reg         nxt_eprom_program_enable;
  reg         clock_output_enable_ff;
  reg         eeprom_erase_select_ff;
  reg         eeprom_latch_enable_ff;
  reg         eeprom_pump_enable_ff;
  reg         ack_ff;
  reg  [7:0]  opt_ff;
  reg         opt_loaded_ff;
  reg  [7:0]  arr_ff [0:15];
  reg  [14:0] arr_addr_ff;
  reg  [7:0]  lat_data_ff [0:15];
  reg  [15:0] lat_valid_ff;
  reg  [11:0] lat_row_ff;
  reg  [3:0]  lat_last_ff;
  reg  [7:0]  rd_data;
  reg  [7:0]  mask_or;
  integer     i;

  wire req       = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire hit_ctrl  = (wb_adr_i == `ERAC_CTRL_ADDR);
  wire hit_opt   = (wb_adr_i == `ERAC_OPT_ADDR);
  wire [15:0] arr_off = wb_adr_i - `ERAC_EPROM_BASE;
  wire hit_arr   = (wb_adr_i >= `ERAC_EPROM_BASE) &&
                   (arr_off < `ERAC_EPROM_BYTES);                      // [RL8]
  wire mapped    = hit_ctrl | hit_opt | hit_arr;
  wire wr        = req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl   = wr & hit_ctrl;
  wire wr_arr    = wr & hit_arr & eprom_latch_enable_ff & ~eprom_program_enable_ff;
  wire any_rst   = rst_i | ext_rst_i;

  assign wb_ack_o     = ack_ff & mapped;
  assign wb_err_o     = ack_ff & ~mapped;
  assign read_mode_o  = ~eprom_latch_enable_ff;
  assign vector_ok_o  = vector_i & ~eprom_latch_enable_ff;              // [RL4]
  assign prog_on_o    = eprom_program_enable_ff;
  assign clk_out_en_o = clock_output_enable_ff;
  assign prog_cnt_o   = lat_last_ff;
  assign prog_row_o   = lat_row_ff;
  assign prog_mask_o  = mask_or;

  // one wait state; ack drops the cycle after it was given
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always @* begin
    nxt_eprom_latch_enable   = eprom_latch_enable_ff;
    nxt_eprom_program_enable = eprom_program_enable_ff;
    if (wr_ctrl) begin
      nxt_eprom_latch_enable = wb_dat_i[`ERAC_LAT_BIT];
      // program enable only sets once latched with a byte present
      if (wb_dat_i[`ERAC_PGM_BIT] && eprom_latch_enable_ff && (lat_valid_ff != 16'h0000)) begin
        nxt_eprom_program_enable = 1'b1;
      end                                                               // [RL12]
    end
    if (stop_i || any_rst) begin
      nxt_eprom_latch_enable = 1'b0;                                    // [RL6] [RL11]
    end
    if (!nxt_eprom_latch_enable) begin
      nxt_eprom_program_enable = 1'b0;                                  // [RL1]
    end
  end

  always @(posedge clk_i) begin
    if (any_rst) begin
      eprom_latch_enable_ff   <= 1'b0;                                  // [RL11]
      eprom_program_enable_ff <= 1'b0;
      clock_output_enable_ff  <= 1'b0;
      eeprom_erase_select_ff  <= 1'b0;
      eeprom_latch_enable_ff  <= 1'b0;
      eeprom_pump_enable_ff   <= 1'b0;
    end else begin
      eprom_latch_enable_ff   <= nxt_eprom_latch_enable;
      eprom_program_enable_ff <= nxt_eprom_program_enable;
      if (wr_ctrl) begin
        clock_output_enable_ff <= wb_dat_i[`ERAC_CLKO_BIT];
      end
      // eeprom bits are held but not sequenced here; stop clears their latch
      if (stop_i) begin
        eeprom_latch_enable_ff <= 1'b0;
        eeprom_erase_select_ff <= 1'b0;
        eeprom_pump_enable_ff  <= 1'b0;
      end else if (wr_ctrl) begin
        eeprom_latch_enable_ff <= wb_dat_i[`ERAC_ELAT_BIT];
        eeprom_erase_select_ff <= wb_dat_i[`ERAC_ELAT_BIT] & wb_dat_i[`ERAC_ERA_BIT];
        eeprom_pump_enable_ff  <= wb_dat_i[`ERAC_ELAT_BIT] & wb_dat_i[`ERAC_EPGM_BIT];
      end
    end
  end

  // option word taken from cells after release; no reset touches it afterwards
  always @(posedge clk_i) begin
    if (!opt_loaded_ff && !rst_i) begin
      opt_ff        <= opt_cells_i;                                     // [RL10]
      opt_loaded_ff <= 1'b1;
    end
    if (rst_i && !opt_loaded_ff) begin
      opt_ff <= `ERAC_OPT_RESET;
    end
  end
  initial opt_loaded_ff = 1'b0;

  // programming latch: up to 16 bytes sharing upper address bits
  always @(posedge clk_i) begin
    if (any_rst || !eprom_latch_enable_ff) begin
      lat_valid_ff <= 16'h0000;
      lat_row_ff   <= 12'h000;
      lat_last_ff  <= 4'h0;
    end else if (wr_arr) begin
      if (lat_valid_ff == 16'h0000 || arr_off[15:4] == lat_row_ff) begin
        lat_data_ff[arr_off[3:0]]  <= wb_dat_i;                         // [RL9]
        lat_valid_ff[arr_off[3:0]] <= 1'b1;
        lat_row_ff                 <= arr_off[15:4];
        lat_last_ff                <= arr_off[3:0];
      end
    end
  end

  always @* begin
    mask_or = 8'h00;
    for (i = 0; i < `ERAC_LATCH_BYTES; i = i + 1) begin
      if (lat_valid_ff[i]) begin
        mask_or = mask_or | lat_data_ff[i];
      end
    end
  end

  // small model window of array cells: programming ors ones into erased zeros
  always @(posedge clk_i) begin
    if (rst_i && !opt_loaded_ff) begin
      for (i = 0; i < `ERAC_LATCH_BYTES; i = i + 1) begin
        arr_ff[i] <= `ERAC_ERASED_BYTE;                                 // [RL7]
      end
      arr_addr_ff <= 15'h0000;
    end else if (eprom_program_enable_ff) begin
      // window row is kept apart from the latch row, which clears with the latch
      arr_addr_ff <= {3'b000, lat_row_ff};
      for (i = 0; i < `ERAC_LATCH_BYTES; i = i + 1) begin
        if (lat_valid_ff[i]) begin
          arr_ff[i] <= arr_ff[i] | lat_data_ff[i];
        end
      end
    end
  end

  always @* begin
    rd_data = 8'h00;
    if (hit_ctrl) begin
      rd_data[`ERAC_LAT_BIT]  = eprom_latch_enable_ff;
      rd_data[`ERAC_PGM_BIT]  = eprom_program_enable_ff;
      rd_data[`ERAC_CLKO_BIT] = clock_output_enable_ff;
      rd_data[`ERAC_ERA_BIT]  = eeprom_erase_select_ff;
      rd_data[`ERAC_ELAT_BIT] = eeprom_latch_enable_ff;
      rd_data[`ERAC_EPGM_BIT] = eeprom_pump_enable_ff;
    end else if (hit_opt) begin
      rd_data = eprom_latch_enable_ff ? `ERAC_BAD_READ : opt_ff;
    end else if (hit_arr) begin
      if (eprom_latch_enable_ff) begin
        rd_data = `ERAC_BAD_READ;                                       // [RL3]
      end else if (arr_off[15:4] == arr_addr_ff[11:0]) begin
        rd_data = arr_ff[arr_off[3:0]];                                 // [RL2]
      end else begin
        rd_data = `ERAC_ERASED_BYTE;                                    // [RL7]
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 8'h00;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

endmodule

/* File: common/erac_map.vh */
// register offsets, field positions and reset values for the eprom read-access block
`ifndef ERAC_MAP_VH
`define ERAC_MAP_VH
`define ERAC_CTRL_ADDR      16'h0007
`define ERAC_OPT_ADDR       16'h7FDE
`define ERAC_CTRL_RESET     8'h00
`define ERAC_LAT_BIT        5
`define ERAC_PGM_BIT        4
`define ERAC_CLKO_BIT       3
`define ERAC_ERA_BIT        2
`define ERAC_ELAT_BIT       1
`define ERAC_EPGM_BIT       0
`define ERAC_EPROM_BASE     16'h8000
`define ERAC_EPROM_BYTES    16'h7A00
`define ERAC_VECTOR_BYTES   14
`define ERAC_EEPROM_BYTES   256
`define ERAC_LATCH_BYTES    16
`define ERAC_ERASED_BYTE    8'h00
`define ERAC_BAD_READ       8'hFF
`define ERAC_OPT_RESET      8'h00
`define ERAC_WB_ADR_W       16
`endif

/* File: dv/erac_monitor.sv */
// port-level checks for the eprom read-access control block
`timescale 1ns/1ps
`include "erac_map.vh"
module erac_monitor (
  input wire        clk_i,       // cpu clock
  input wire        rst_i,       // sync reset
  input wire        ext_rst_i,   // external reset
  input wire        stop_i,      // stop entry
  input wire        wb_cyc_i,    // bus cycle
  input wire        wb_stb_i,    // bus strobe
  input wire        wb_we_i,     // bus write
  input wire [15:0] wb_adr_i,    // bus address
  input wire [7:0]  wb_dat_o,    // read data
  input wire        wb_ack_o,    // acknowledge
  input wire        wb_err_o,    // error
  input wire [7:0]  opt_cells_i, // option cells
  input wire        vector_i,    // vector fetch
  input wire        vector_ok_o, // vector valid
  input wire        read_mode_o, // read mode
  input wire        prog_on_o    // program enable
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire rd  = wb_ack_o && !wb_we_i;
  wire arr = wb_adr_i >= `ERAC_EPROM_BASE && wb_adr_i < `ERAC_EPROM_BASE + `ERAC_EPROM_BYTES;
  AST_PGM_NEEDS_LATCH: assert property (read_mode_o |-> !prog_on_o)
    else $error("program enable seen in read mode");
  AST_PGM_FALLS_WITH_LATCH: assert property ($fell(prog_on_o) |-> read_mode_o)
    else $error("program enable cleared with latch still set");
  AST_VECTOR_GATED: assert property (vector_ok_o == (vector_i && read_mode_o))
    else $error("vector valid does not follow latch");
  AST_STOP_READ_MODE: assert property (stop_i |=> read_mode_o && !prog_on_o)
    else $error("stop did not restore read mode");
  AST_EXT_RST_LATCH: assert property (ext_rst_i |=> read_mode_o)
    else $error("external reset left latch set");
  AST_ONE_WAIT: assert property (req |=> (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o))
    else $error("bus answer not one cycle after request");
  AST_LATCHED_READ: assert property (rd && arr && !read_mode_o |-> wb_dat_o == `ERAC_BAD_READ)
    else $error("array read with latch set gave cell data");
  AST_OPT_WORD: assert property (rd && wb_adr_i == `ERAC_OPT_ADDR && read_mode_o
    |-> wb_dat_o == opt_cells_i)
    else $error("option word read mismatch");
  COV_STOP: cover property (stop_i && !read_mode_o);
  COV_PGM: cover property ($rose(prog_on_o));
  COV_ERR: cover property (wb_err_o);
endmodule
bind erac_top erac_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .ext_rst_i(ext_rst_i),
  .stop_i(stop_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .opt_cells_i(opt_cells_i), .vector_i(vector_i), .vector_ok_o(vector_ok_o),
  .read_mode_o(read_mode_o), .prog_on_o(prog_on_o));

/* File: dv/erac_cpu_model.sv */
// cpu core side: instruction and vector fetch qualifiers
`timescale 1ns/1ps
module erac_cpu_model (
  input  wire clk_i,           // cpu clock
  input  wire read_mode_i,     // eprom in read mode
  input  wire fetch_req_i,     // fetch wanted
  input  wire vec_req_i,       // vector fetch wanted
  input  wire boot_req_i,      // bootstrap routine wanted
  output reg  fetch_o = 1'b0,  // fetch qualifier
  output reg  vector_o = 1'b0  // vector qualifier
);
  always @(posedge clk_i) begin
    // bootstrap code cannot run behind a set latch, so only start it in read mode
    fetch_o  <= fetch_req_i | (boot_req_i & read_mode_i);
    vector_o <= vec_req_i;
  end
endmodule

/* File: dv/erac_top_bench.sv */
// self-checking bench for the eprom read-access control block
`timescale 1ns/1ps
`include "erac_map.vh"
module erac_top_bench;
  localparam logic [7:0] OPT = 8'hA5;  // arbitrary option cell pattern
  localparam logic [15:0] CT = `ERAC_CTRL_ADDR;
  logic        clk = 0, rst = 1, xrst = 0, stp = 0, cyc = 0, stb = 0, we = 0, ef;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  dat = 8'h00, q;
  wire  [7:0]  rdat, pmask;
  wire  [3:0]  pcnt;
  wire  [11:0] prow;
  wire         ack, err, fch, vec, rmode;
  int          error_cnt = 0, num_checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  erac_cpu_model cpu (.clk_i(clk), .read_mode_i(rmode), .fetch_req_i(1'b1),
    .vec_req_i(1'b1), .boot_req_i(1'b0), .fetch_o(fch), .vector_o(vec));
  erac_top uut (.clk_i(clk), .rst_i(rst), .ext_rst_i(xrst), .stop_i(stp), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(1'b1),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .opt_cells_i(OPT), .fetch_i(fch),
    .vector_i(vec), .vector_ok_o(), .read_mode_o(rmode), .prog_on_o(), .clk_out_en_o(),
    .prog_cnt_o(pcnt), .prog_mask_o(pmask), .prog_row_o(prow));
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (!(ack | err));
    q = rdat;
    ef = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task pulse(input int k);
    @(posedge clk);
    if (k == 0) stp <= 1'b1;
    else if (k == 1) xrst <= 1'b1;
    else rst <= 1'b1;
    @(posedge clk);
    stp  <= 1'b0;
    xrst <= 1'b0;
    rst  <= 1'b0;
  endtask
  task wrap_up;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    // generous ceiling; the whole sequence needs about 135 cycles
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(CT, `ERAC_CTRL_RESET);
    rd(`ERAC_OPT_ADDR, OPT);
    rd(`ERAC_EPROM_BASE, `ERAC_ERASED_BYTE);
    rd(`ERAC_EPROM_BASE + `ERAC_EPROM_BYTES - 16'h0001, `ERAC_ERASED_BYTE);
    acc(1'b0, 16'h0008, 8'h00);
    chk({7'h00, ef}, 8'h01);
    acc(1'b1, CT, 8'h20);
    rd(CT, 8'h20);
    rd(`ERAC_EPROM_BASE, `ERAC_BAD_READ);
    for (logic [4:0] i = 0; i < 16; i++) acc(1'b1, {12'h801, i[3:0]}, 8'h01 << i[2:0]);
    chk({4'h0, pcnt}, 8'h0F);
    chk(pmask, 8'hFF);
    chk(prow[7:0], 8'h01);
    acc(1'b1, CT, 8'h30);
    rd(CT, 8'h30);
    acc(1'b1, CT, 8'h20);
    rd(CT, 8'h30);
    acc(1'b1, CT, 8'h00);
    rd(CT, 8'h00);
    rd(`ERAC_EPROM_BASE, `ERAC_ERASED_BYTE);
    rd(`ERAC_EPROM_BASE + 16'h0013, 8'h08);
    acc(1'b1, CT, 8'h20);
    pulse(0);
    rd(CT, 8'h00);
    acc(1'b1, CT, 8'h20);
    pulse(1);
    rd(CT, 8'h00);
    acc(1'b1, CT, 8'h20);
    pulse(2);
    rd(CT, 8'h00);
    rd(`ERAC_OPT_ADDR, OPT);
    wrap_up();
  end
endmodule
